// ==== include/icsts_pkg.sv ====
// Shared constants for the clock source trim and status block
`default_nettype none
package icsts_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_TRIM = 8'h00;
  localparam logic [7:0] OFF_STATUS_CTRL = 8'h04;
  localparam logic [7:0] OFF_SOURCE_CTRL = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_FLL_FACTOR = 8'h14;
  // Reset and debug load values
  localparam logic [7:0] TRIM_DEBUG = 8'h80;
  localparam logic FINE_DEBUG = 1'b0;
  // Status and control field positions
  localparam int SC_RANGE_LSB = 6;
  localparam int SC_DMX = 5;
  localparam int SC_REF = 4;
  localparam int SC_MODE_LSB = 2;
  localparam int SC_OSC = 1;
  localparam int SC_FINE = 0;
  // Source control field positions
  localparam int SRC_CLOCK_SOURCE_SELECT_LSB = 0;
  localparam int SRC_INTERNAL_REFERENCE_SELECT = 2;
  localparam int SRC_LP = 3;
  localparam int SRC_OSCILLATOR_REQUEST = 4;
  localparam int SRC_EXTERNAL_REFERENCE_ENABLE = 5;
  localparam logic [5:0] SRC_RESET = 6'h04;
  // Interrupt event bits
  localparam int EV_OSC = 0;
  localparam int EV_RANGE = 1;
  localparam int EV_MODE = 2;
  localparam int EV_REF = 3;
  localparam int EV_W = 4;
  // Encodings
  localparam logic [1:0] RANGE_LOW = 2'h0;
  localparam logic [1:0] RANGE_MID = 2'h1;
  localparam logic [1:0] RANGE_HIGH = 2'h2;
  localparam logic [1:0] RANGE_RSVD = 2'h3;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_FLL = 2'h0;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_INT = 2'h1;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_EXT = 2'h2;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_RSVD = 2'h3;
  // FLL multiplication factor per range step
  localparam logic [10:0] FACTOR_STEP_DEF = 11'h200;
  localparam logic [10:0] FACTOR_STEP_MAX = 11'h260;
  localparam int OSC_START_CYCLES = 1024;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : icsts_pkg
`default_nettype wire

// ==== verilog/icsts_sync.sv ====
// Two-stage synchroniser for the status mirrors
`default_nettype none
module icsts_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= INIT;
      q_r <= INIT;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule : icsts_sync
`default_nettype wire

// ==== verilog/icsts_osc_start.sv ====
// Oscillator start-up counter and ready flag
`default_nettype none
module icsts_osc_start #(
  parameter int CYCLES = icsts_pkg::OSC_START_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic clear_i,
  output logic ready_o
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic ready_r;
  logic ready_nxt;

  // Count start-up cycles; only a clear drops the flag
  always_comb begin
    cnt_nxt = cnt_r;
    ready_nxt = ready_r;
    if (clear_i) begin
      cnt_nxt = '0;
      ready_nxt = 1'b0;
    end else if (start_i && !ready_r) begin
      if (cnt_r == 16'(CYCLES - 1)) begin
        ready_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign ready_o = ready_r;
endmodule : icsts_osc_start
`default_nettype wire

// ==== verilog/icsts_top.sv ====
// Clock source trim, range control and status with AXI4-Lite access
// Function
// - Reset loads coarse trim from factory value, or 0x80 in debug mode
// - Coarse trim bits are binary weighted on the reference period
// - Larger coarse trim lengthens the period, smaller shortens it
// - Reset loads fine trim from factory value, or zero in debug mode
// - Fine trim set lengthens the period by the smallest step
// - Range select: 00 low, 01 mid, 10 high, 11 reserved
// - Range select writes are ignored while low-power disable is set
// - Writing reserved range 11 is ignored, status keeps its value
// - Range status shows range in effect after synchronisation
// - Max bit clear gives default range, set tunes for 32.768 kHz
// - Default factors: 512 low, 1024 mid, 1536 high
// - Max factors: 608 low, 1216 mid, 1824 high
// - Reference status reads 1 for internal, after synchronisation
// - Clock mode status follows source select after synchronisation
// - Oscillator ready sets after start-up when external and requested
// - Oscillator ready clears only when request clears, or when enable is clear and no external mode is in use
// - Source select 00 FLL, 01 internal, 10 external, 11 acts as 00
// - Oscillator request set asks for crystal, clear for clock input
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module icsts_top #(
  parameter int OSC_CYCLES = icsts_pkg::OSC_START_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic debug_mode_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic factory_fine_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] trim_o,
  output logic fine_period_adjust_o,
  output logic [1:0] dco_range_o,
  output logic dco_max_for_32k_ref_o,
  output logic [10:0] fll_factor_o,
  output logic [1:0] clock_mode_o,
  output logic reference_internal_o,
  output logic crystal_request_o,
  output logic irq_o
);
  // Register state
  logic [7:0] trim_r, trim_nxt;
  logic fine_r, fine_nxt;
  logic [1:0] range_sel_r, range_sel_nxt;
  logic dmx_r, dmx_nxt;
  logic [5:0] src_r, src_nxt;
  logic [3:0] irq_st_r, irq_st_nxt;
  logic [3:0] irq_mask_r, irq_mask_nxt;
  logic loaded_r, loaded_nxt;
  // Bus state
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Derived signals
  logic wr_go, rd_go, wr_b0;
  logic [1:0] clock_source_select_eff;
  logic [4:0] sync_in, sync_out;
  logic [1:0] range_st, mode_st;
  logic ref_st, osc_ready;
  logic ext_mode, ext_selected, osc_clear;
  logic [4:0] sync_prev_r;
  logic osc_prev_r;
  logic [3:0] events;
  logic [7:0] sc_read;
  logic [10:0] factor;

  // FLL factor is the range step times range plus one
  function automatic logic [10:0] fll_factor(input logic [1:0] rng,
                                             input logic maxed);
    logic [10:0] step;
    step = maxed ? icsts_pkg::FACTOR_STEP_MAX
                 : icsts_pkg::FACTOR_STEP_DEF;
    case (rng)
      icsts_pkg::RANGE_LOW: fll_factor = step;
      icsts_pkg::RANGE_MID: fll_factor = 11'(step << 1);
      icsts_pkg::RANGE_HIGH: fll_factor = 11'(step + (step << 1));
      default: fll_factor = step;
    endcase
  endfunction : fll_factor

  // Write takes address and data together; read waits for empty slot
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign wr_b0 = wr_go && s_axi_wstrb[0];
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // Reserved source select acts as FLL output
  assign clock_source_select_eff = (src_r[icsts_pkg::SRC_CLOCK_SOURCE_SELECT_LSB +: 2] ==
                     icsts_pkg::CLOCK_SOURCE_SELECT_RSVD) ? icsts_pkg::CLOCK_SOURCE_SELECT_FLL
                    : src_r[icsts_pkg::SRC_CLOCK_SOURCE_SELECT_LSB +: 2];

  // Selections cross to the status view through the synchroniser
  assign sync_in = {range_sel_r, clock_source_select_eff, src_r[icsts_pkg::SRC_INTERNAL_REFERENCE_SELECT]};
  icsts_sync #(
    .W(5),
    .INIT(5'h01)
  ) u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .d_i(sync_in),
    .q_o(sync_out)
  );
  assign range_st = sync_out[4:3];
  assign mode_st = sync_out[2:1];
  assign ref_st = sync_out[0];

  // External reference in use by enable bit or by mode
  assign ext_mode = !ref_st && (mode_st == icsts_pkg::CLOCK_SOURCE_SELECT_FLL ||
                                mode_st == icsts_pkg::CLOCK_SOURCE_SELECT_EXT);
  assign ext_selected = src_r[icsts_pkg::SRC_EXTERNAL_REFERENCE_ENABLE] || ext_mode;
  assign osc_clear = !src_r[icsts_pkg::SRC_OSCILLATOR_REQUEST] ||
                     !src_r[icsts_pkg::SRC_EXTERNAL_REFERENCE_ENABLE] && !ext_mode;
  icsts_osc_start #(
    .CYCLES(OSC_CYCLES)
  ) u_osc (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .start_i(ext_selected && src_r[icsts_pkg::SRC_OSCILLATOR_REQUEST]),
    .clear_i(osc_clear),
    .ready_o(osc_ready)
  );

  // Factor uses the range actually in effect
  assign factor = fll_factor(range_st, dmx_r);

  // Status changes become interrupt events
  assign events[icsts_pkg::EV_OSC] = osc_ready && !osc_prev_r;
  assign events[icsts_pkg::EV_RANGE] = range_st != sync_prev_r[4:3];
  assign events[icsts_pkg::EV_MODE] = mode_st != sync_prev_r[2:1];
  assign events[icsts_pkg::EV_REF] = ref_st != sync_prev_r[0];

  // Read view: status fields over the write-only selects
  assign sc_read = {range_st, dmx_r, ref_st, mode_st, osc_ready, fine_r};

  // Register next values
  always_comb begin
    trim_nxt = trim_r;
    fine_nxt = fine_r;
    range_sel_nxt = range_sel_r;
    dmx_nxt = dmx_r;
    src_nxt = src_r;
    irq_mask_nxt = irq_mask_r;
    loaded_nxt = 1'b1;
    irq_st_nxt = irq_st_r;
    // Factory values replace debug defaults at the first edge after reset
    if (!loaded_r && !debug_mode_i) begin
      trim_nxt = factory_trim_i;
      fine_nxt = factory_fine_i;
    end
    if (wr_b0) begin
      if (s_axi_awaddr == icsts_pkg::OFF_TRIM) begin
        trim_nxt = s_axi_wdata[7:0];
      end else if (s_axi_awaddr == icsts_pkg::OFF_STATUS_CTRL) begin
        fine_nxt = s_axi_wdata[icsts_pkg::SC_FINE];
        dmx_nxt = s_axi_wdata[icsts_pkg::SC_DMX];
        // Status bit positions are not stored
        if (!src_r[icsts_pkg::SRC_LP] &&
            s_axi_wdata[icsts_pkg::SC_RANGE_LSB +: 2] !=
            icsts_pkg::RANGE_RSVD) begin
          range_sel_nxt = s_axi_wdata[icsts_pkg::SC_RANGE_LSB +: 2];
        end
      end else if (s_axi_awaddr == icsts_pkg::OFF_SOURCE_CTRL) begin
        src_nxt = s_axi_wdata[5:0];
      end else if (s_axi_awaddr == icsts_pkg::OFF_IRQ_STATUS) begin
        irq_st_nxt = irq_st_r & ~s_axi_wdata[3:0];
      end else if (s_axi_awaddr == icsts_pkg::OFF_IRQ_MASK) begin
        irq_mask_nxt = s_axi_wdata[3:0];
      end
    end
    // A new event wins over a clear in the same cycle
    irq_st_nxt = irq_st_nxt | events;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trim_r <= icsts_pkg::TRIM_DEBUG;
      fine_r <= icsts_pkg::FINE_DEBUG;
      range_sel_r <= icsts_pkg::RANGE_LOW;
      dmx_r <= 1'b0;
      src_r <= icsts_pkg::SRC_RESET;
      irq_st_r <= '0;
      irq_mask_r <= '0;
      loaded_r <= 1'b0;
    end else begin
      trim_r <= trim_nxt;
      fine_r <= fine_nxt;
      range_sel_r <= range_sel_nxt;
      dmx_r <= dmx_nxt;
      src_r <= src_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // Previous status values for change detection
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_prev_r <= 5'h01;
      osc_prev_r <= 1'b0;
    end else begin
      sync_prev_r <= sync_out;
      osc_prev_r <= osc_ready;
    end
  end

  // Bus responses; unmapped addresses answer SLVERR
  always_comb begin
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (s_axi_awaddr <= icsts_pkg::OFF_IRQ_MASK &&
                   s_axi_awaddr[1:0] == 2'h0) ? icsts_pkg::RESP_OKAY
                  : icsts_pkg::RESP_SLVERR;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = icsts_pkg::RESP_OKAY;
      if (s_axi_araddr == icsts_pkg::OFF_TRIM) begin
        rdata_nxt = {24'h000000, trim_r};
      end else if (s_axi_araddr == icsts_pkg::OFF_STATUS_CTRL) begin
        rdata_nxt = {24'h000000, sc_read};
      end else if (s_axi_araddr == icsts_pkg::OFF_SOURCE_CTRL) begin
        rdata_nxt = {26'h0000000, src_r};
      end else if (s_axi_araddr == icsts_pkg::OFF_IRQ_STATUS) begin
        rdata_nxt = {28'h0000000, irq_st_r};
      end else if (s_axi_araddr == icsts_pkg::OFF_IRQ_MASK) begin
        rdata_nxt = {28'h0000000, irq_mask_r};
      end else if (s_axi_araddr == icsts_pkg::OFF_FLL_FACTOR) begin
        rdata_nxt = {21'h000000, factor};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = icsts_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= icsts_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= icsts_pkg::RESP_OKAY;
      rdata_r <= '0;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign trim_o = trim_r;
  assign fine_period_adjust_o = fine_r;
  assign dco_range_o = range_st;
  assign dco_max_for_32k_ref_o = dmx_r;
  assign fll_factor_o = factor;
  assign clock_mode_o = mode_st;
  assign reference_internal_o = ref_st;
  assign crystal_request_o = src_r[icsts_pkg::SRC_OSCILLATOR_REQUEST];
  assign irq_o = |(irq_st_r & irq_mask_r);

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_trim_debug_load: assert property (
    $rose(loaded_r) && $past(debug_mode_i) |-> trim_r == 8'h80)
    else $error("Debug reset did not keep trim at 0x80");
  a_fine_debug_load: assert property (
    $rose(loaded_r) && $past(debug_mode_i) |-> !fine_r)
    else $error("Debug reset did not keep fine trim at zero");
  a_range_lp_block: assert property (
    wr_b0 && s_axi_awaddr == icsts_pkg::OFF_STATUS_CTRL &&
    src_r[icsts_pkg::SRC_LP] |=> $stable(range_sel_r))
    else $error("Range select changed while low power set");
  a_range_rsvd_drop: assert property (
    range_sel_r != icsts_pkg::RANGE_RSVD)
    else $error("Reserved range stored");
  a_range_sync_lag: assert property (
    $changed(range_sel_r) |-> ##2 range_st == $past(range_sel_r, 2))
    else $error("Range status did not follow after two cycles");
  a_factor_value: assert property (
    range_st == icsts_pkg::RANGE_HIGH |->
      fll_factor_o == (dmx_r ? 11'd1824 : 11'd1536))
    else $error("Wrong FLL factor for high range");
  a_ref_sync_lag: assert property (
    ##2 ref_st == $past(src_r[icsts_pkg::SRC_INTERNAL_REFERENCE_SELECT], 2))
    else $error("Reference status not two cycles behind select");
  a_mode_rsvd: assert property (
    mode_st != icsts_pkg::CLOCK_SOURCE_SELECT_RSVD)
    else $error("Clock mode status shows reserved code");
  a_osc_clear_only: assert property (
    $fell(osc_ready) |-> $past(osc_clear))
    else $error("Oscillator ready dropped without a clear");
  a_osc_needs_req: assert property (
    $rose(osc_ready) |-> $past(src_r[icsts_pkg::SRC_OSCILLATOR_REQUEST] && ext_selected))
    else $error("Oscillator ready set without request");
  a_status_readonly: assert property (
    wr_b0 && s_axi_awaddr == icsts_pkg::OFF_STATUS_CTRL |=>
      $stable(src_r))
    else $error("Status write disturbed source control");

  c_range_write: cover property (wr_b0 &&
    s_axi_awaddr == icsts_pkg::OFF_STATUS_CTRL ##3 $changed(range_st));
  c_osc_ready: cover property ($rose(osc_ready));
  c_irq_raise: cover property ($rose(irq_o));
  c_read_err: cover property (rd_go && rresp_nxt == icsts_pkg::RESP_SLVERR);
endmodule : icsts_top
`default_nettype wire

// ==== bench/test_clock_source_trim_status.sv ====
// Self-checking bench for the clock source trim and status block
`default_nettype none
module test_clock_source_trim_status;
  timeunit 1ns;
  timeprecision 1ps;
  // Short start-up count keeps the oscillator waits brief
  localparam int OSC_N = 4;
  logic clock_i, arst_n_i, debug_mode_i, factory_fine_i;
  logic [7:0] factory_trim_i, s_axi_awaddr, s_axi_araddr, trim_o;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, dco_range_o, clock_mode_o;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, fine_period_adjust_o;
  logic dco_max_for_32k_ref_o, reference_internal_o;
  logic crystal_request_o, irq_o;
  logic [10:0] fll_factor_o;
  int fail_count;
  int samples_checked;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  // Multiplication factors per max bit and range
  logic [10:0] fac [2][3] = '{'{11'h200, 11'h400, 11'h600},
                              '{11'h260, 11'h4c0, 11'h720}};

  icsts_top #(.OSC_CYCLES(OSC_N)) icsts_top_inst (
    .clock_i, .arst_n_i, .debug_mode_i, .factory_trim_i, .factory_fine_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trim_o, .fine_period_adjust_o, .dco_range_o,
    .dco_max_for_32k_ref_o, .fll_factor_o, .clock_mode_o,
    .reference_internal_o, .crystal_request_o, .irq_o
  );

  // 50 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // Waits n edges, then lets that edge's updates land before sampling
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wt

  // Write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] rsp = icsts_pkg::RESP_OKAY);
    @(posedge clock_i);
    bq.push_back(rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clock_i); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clock_i); while (s_axi_bvalid !== 1'b1);
    #1;
  endtask : wr

  // Read: expected answer noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rsp = icsts_pkg::RESP_OKAY);
    @(posedge clock_i);
    rq.push_back({rsp, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_i); while (s_axi_rvalid !== 1'b1);
    #1;
  endtask : rd

  // Reads status/control and expects the given field values
  task automatic sc_rd(input logic [1:0] r, input logic m, f,
                       input logic [1:0] md, input logic ri, os);
    rd(icsts_pkg::OFF_STATUS_CTRL, {24'h0, r, m, ri, md, os, f});
  endtask : sc_rd

  task automatic do_reset(input logic dbg);
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    debug_mode_i <= dbg;
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    wt(2);
  endtask : do_reset

  // Answers are matched against the oldest note; ready is held high
  always @(posedge clock_i) begin
    if (s_axi_rvalid === 1'b1) begin
      chk("rdata", rq.size() ? rq.pop_front() : 'x,
          {s_axi_rresp, s_axi_rdata});
    end
    if (s_axi_bvalid === 1'b1) begin
      chk("bresp", bq.size() ? 34'(bq.pop_front()) : 'x,
          34'(s_axi_bresp));
    end
  end

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    logic [1:0] rng;
    logic [1:0] prev;
    logic [1:0] md;
    logic mx;
    logic [7:0] tv;
    fail_count = 0;
    samples_checked = 0;
    arst_n_i = 1'b0;
    debug_mode_i = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    void'($urandom(59));
    factory_trim_i = 8'($urandom());
    factory_fine_i = 1'($urandom());
    // Normal reset loads the factory values
    do_reset(1'b0);
    chk("trim_o", factory_trim_i, trim_o);
    rd(icsts_pkg::OFF_TRIM, {24'h0, factory_trim_i});
    sc_rd(2'h0, 1'b0, factory_fine_i, 2'h0, 1'b1, 1'b0);
    rd(icsts_pkg::OFF_SOURCE_CTRL, 32'h4);
    rd(icsts_pkg::OFF_IRQ_MASK, 32'h0);
    rd(icsts_pkg::OFF_FLL_FACTOR, 32'h200);
    // Walking one, then a random value, through the coarse trim
    for (int i = 0; i < 9; i++) begin
      prev = 2'h0;
      mx = 1'b0;
      rng = 2'h0;
      md = 2'h0;
      wr(icsts_pkg::OFF_TRIM, (i < 8) ? 8'h01 << i : 8'($urandom()));
      chk("trim_o", s_axi_wdata[7:0], trim_o);
    end
    // A write without the low byte lane must leave the trim alone
    tv = s_axi_wdata[7:0];
    s_axi_wstrb <= 4'he;
    wr(icsts_pkg::OFF_TRIM, ~tv);
    s_axi_wstrb <= 4'hf;
    chk("trim_o", tv, trim_o);
    wr(icsts_pkg::OFF_STATUS_CTRL, 8'h01);
    chk("fine", 1'b1, fine_period_adjust_o);
    sc_rd(2'h0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0);
    // Every range with both max settings; status lags two edges
    for (int i = 0; i < 6; i++) begin
      rng = 2'(i % 3);
      mx = 1'(i / 3);
      wr(icsts_pkg::OFF_STATUS_CTRL, {rng, mx, 5'h0});
      chk("range_early", prev, dco_range_o);
      wt(1);
      chk("dco_range_o", rng, dco_range_o);
      chk("fll_factor_o", fac[mx][rng], fll_factor_o);
      chk("dco_max", mx, dco_max_for_32k_ref_o);
      sc_rd(rng, mx, 1'b0, 2'h0, 1'b1, 1'b0);
      prev = rng;
    end
    // Reserved range, and a range write under low-power disable
    wr(icsts_pkg::OFF_STATUS_CTRL, 8'he0);
    wt(4);
    chk("dco_range_o", 2'h2, dco_range_o);
    wr(icsts_pkg::OFF_SOURCE_CTRL, 8'h0c);
    wr(icsts_pkg::OFF_STATUS_CTRL, 8'h20);
    wt(4);
    chk("dco_range_o", 2'h2, dco_range_o);
    // Every source select with both reference selections
    for (int i = 0; i < 8; i++) begin
      md = (i[1:0] == 2'h3) ? 2'h0 : i[1:0];
      wr(icsts_pkg::OFF_SOURCE_CTRL, 8'(i));
      wt(1);
      chk("clock_mode_o", md, clock_mode_o);
      chk("ref_int", i[2], reference_internal_o);
      // Range stays high: the last two range writes were refused
      sc_rd(2'h2, 1'b1, 1'b0, md, i[2], 1'b0);
    end
    // Writes to the status bits leave them alone
    wr(icsts_pkg::OFF_STATUS_CTRL, 8'h3e);
    wt(3);
    sc_rd(2'h0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0);
    wr(icsts_pkg::OFF_FLL_FACTOR, 8'h00, icsts_pkg::RESP_SLVERR);
    wr(8'h18, 8'h01, icsts_pkg::RESP_SLVERR);
    rd(8'h18, 32'h0, icsts_pkg::RESP_SLVERR);
    rd(icsts_pkg::OFF_FLL_FACTOR, 32'h260);
    // Oscillator start with enable, clear, start in external mode
    wr(icsts_pkg::OFF_SOURCE_CTRL, 8'h34);
    chk("xtal_req", 1'b1, crystal_request_o);
    wt(OSC_N + 4);
    sc_rd(2'h0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b1);
    wr(icsts_pkg::OFF_SOURCE_CTRL, 8'h14);
    wt(3);
    sc_rd(2'h0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0);
    wr(icsts_pkg::OFF_SOURCE_CTRL, 8'h10);
    wt(OSC_N + 6);
    sc_rd(2'h0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1);
    wr(icsts_pkg::OFF_SOURCE_CTRL, 8'h12);
    wt(3);
    sc_rd(2'h0, 1'b1, 1'b0, 2'h2, 1'b0, 1'b1);
    wr(icsts_pkg::OFF_SOURCE_CTRL, 8'h02);
    chk("xtal_req", 1'b0, crystal_request_o);
    wt(3);
    sc_rd(2'h0, 1'b1, 1'b0, 2'h2, 1'b0, 1'b0);
    // Interrupt: clear all, raise masked, unmask, clear by writing one
    wr(icsts_pkg::OFF_IRQ_MASK, 8'h00);
    wr(icsts_pkg::OFF_IRQ_STATUS, 8'h0f);
    rd(icsts_pkg::OFF_IRQ_STATUS, 32'h0);
    wr(icsts_pkg::OFF_STATUS_CTRL, 8'h60);
    wt(3);
    chk("irq_o", 1'b0, irq_o);
    rd(icsts_pkg::OFF_IRQ_STATUS, 32'h2);
    wr(icsts_pkg::OFF_IRQ_MASK, 8'h02);
    chk("irq_o", 1'b1, irq_o);
    wr(icsts_pkg::OFF_IRQ_STATUS, 8'h02);
    chk("irq_o", 1'b0, irq_o);
    rd(icsts_pkg::OFF_IRQ_STATUS, 32'h0);
    // Mid-run reset in debug mode ignores the factory values
    factory_trim_i <= 8'h5a;
    factory_fine_i <= 1'b1;
    do_reset(1'b1);
    chk("trim_o", icsts_pkg::TRIM_DEBUG, trim_o);
    chk("fine", 1'b0, fine_period_adjust_o);
    rd(icsts_pkg::OFF_TRIM, 32'h80);
    sc_rd(2'h0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
    chk("fll_factor_o", 11'h200, fll_factor_o);
    finish_test();
  end
endmodule : test_clock_source_trim_status
`default_nettype wire
